// *** shared/cpo_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef CPO_REGS_SVH
`define CPO_REGS_SVH
`define CPO_ADDR          8'h36
`define CPO_RESET         16'h0048
`define CPO_UV_MSB        15
`define CPO_UV_LSB        13
`define CPO_DITH_MSB      12
`define CPO_DITH_LSB      11
`define CPO_NOHIC_BIT     10
`define CPO_PPVAP_BIT     9
`define CPO_VAPFLG_BIT    8
`define CPO_DEG_MSB       7
`define CPO_DEG_LSB       6
`define CPO_PCT_MSB       5
`define CPO_PCT_LSB       3
`define CPO_PPDC2_BIT     2
`define CPO_DC2FLG_BIT    1
`define CPO_PTM_BIT       0
`define CPO_RW_MASK       16'hFEFC
`define CPO_MAX_RESTARTS  3'h7
`define CPO_CLK_HZ        10000000
`define CPO_DEG0_US       100
`define CPO_DEG1_US       1600
`define CPO_DEG2_US       6000
`define CPO_DEG3_US       12000
`define CPO_US_CYC(us)    ((us) * (`CPO_CLK_HZ / 1000000))
`endif

// *** shared/cpo_pkg.sv ***
// types for the protection option register block
package cpo_pkg;
	typedef enum logic [2:0] {
		CPO_RUN    = 3'h1,
		CPO_HICCUP = 3'h2,
		CPO_LATCH  = 3'h4
	} cpo_uv_e;

	typedef struct packed {
		logic [15:0] reg_val;
		cpo_uv_e     uv_st;
		logic [2:0]  restarts;
		logic [17:0] deg_cnt;
		logic        dc2_det;
		logic        vap_flag;
		logic        dc2_flag;
		logic [2:0]  uv_sync;
		logic [2:0]  vap_sync;
		logic [2:0]  dc2_sync;
		logic [2:0]  ptm_sync;
		logic [3:0]  flt;
		logic        throttle;
		logic [15:0] rdata;
	} cpo_state_s;
endpackage

// *** hdl/cpo_option_reg.sv ***
// protection option register with undervoltage restart and status flags
`timescale 1ns/1ns
`include "cpo_regs.svh"

// What this block does
// - dither field off, two, four, six percent
// - bit 10 set disables hiccup restart
// - bit 9 gates peak event into throttling
// - peak flag sticky until host reads
// - limit2 deglitch 100us 1.6ms 6ms 12ms
// - register resets to 0048h
// - limit2 percentage field bits 5 to 3
module cpo_option_reg (
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	input  wire logic        sys_uv_i,
	input  wire logic        bus_peak_event_i,
	input  wire logic        dc2_over_i,
	input  wire logic        ptm_active_i,
	output logic      [2:0]  system_undervoltage_threshold_o,
	output logic      [1:0]  dither_range_o,
	output logic      [2:0]  discharge_limit2_percent_o,
	output logic             discharge_limit2_trip_o,
	output logic             processor_throttle_o,
	output logic             converter_enable_o,
	output logic             latched_off_o
);
	cpo_pkg::cpo_state_s s_r;
	cpo_pkg::cpo_state_s s_nxt;
	logic [17:0]         deg_lim;
	logic                hit;
	logic                uv_now;
	logic                vap_now;
	logic                dc2_now;
	logic                ptm_now;

	// =====================================================
	// next state
	always_comb begin
		s_nxt = s_r;
		hit   = reg_addr_i == `CPO_ADDR;
		// three-stage sync; a level change counts only once stages two
		// and three agree, so a one-cycle glitch never reaches the logic
		s_nxt.uv_sync  = {s_r.uv_sync[1:0], sys_uv_i};
		s_nxt.vap_sync = {s_r.vap_sync[1:0], bus_peak_event_i};
		s_nxt.dc2_sync = {s_r.dc2_sync[1:0], dc2_over_i};
		s_nxt.ptm_sync = {s_r.ptm_sync[1:0], ptm_active_i};
		if (s_r.uv_sync[1] == s_r.uv_sync[2]) begin
			s_nxt.flt[0] = s_r.uv_sync[2];
		end
		if (s_r.vap_sync[1] == s_r.vap_sync[2]) begin
			s_nxt.flt[1] = s_r.vap_sync[2];
		end
		if (s_r.dc2_sync[1] == s_r.dc2_sync[2]) begin
			s_nxt.flt[2] = s_r.dc2_sync[2];
		end
		if (s_r.ptm_sync[1] == s_r.ptm_sync[2]) begin
			s_nxt.flt[3] = s_r.ptm_sync[2];
		end
		uv_now  = s_nxt.flt[0];
		vap_now = s_nxt.flt[1];
		dc2_now = s_nxt.flt[2];
		ptm_now = s_nxt.flt[3];
		case (s_r.reg_val[`CPO_DEG_MSB:`CPO_DEG_LSB])
			2'h0:    deg_lim = 18'(`CPO_US_CYC(`CPO_DEG0_US));
			2'h1:    deg_lim = 18'(`CPO_US_CYC(`CPO_DEG1_US));
			2'h2:    deg_lim = 18'(`CPO_US_CYC(`CPO_DEG2_US));
			default: deg_lim = 18'(`CPO_US_CYC(`CPO_DEG3_US));
		endcase
		if (!dc2_now) begin
			s_nxt.deg_cnt = 18'h00000;
			s_nxt.dc2_det = 1'b0;
		end else if (s_r.deg_cnt >= deg_lim - 18'h00001) begin
			s_nxt.dc2_det = 1'b1;
		end else begin
			s_nxt.deg_cnt = s_r.deg_cnt + 18'h00001;
		end
		// read clears, but a new event in the same cycle wins
		if (reg_rd_i && hit) begin
			s_nxt.vap_flag = 1'b0;
			s_nxt.dc2_flag = 1'b0;
		end
		if (vap_now) begin
			s_nxt.vap_flag = 1'b1;
		end
		if (s_r.dc2_det) begin
			s_nxt.dc2_flag = 1'b1;
		end
		if (reg_wr_i && hit) begin
			s_nxt.reg_val = reg_wdata_i & `CPO_RW_MASK;
		end
		s_nxt.rdata = s_r.reg_val;
		s_nxt.rdata[`CPO_VAPFLG_BIT] = s_r.vap_flag;
		s_nxt.rdata[`CPO_DC2FLG_BIT] = s_r.dc2_flag;
		s_nxt.rdata[`CPO_PTM_BIT]    = ptm_now;
		// registered so the throttle pin comes straight from a flop
		s_nxt.throttle =
			(s_r.vap_flag & s_r.reg_val[`CPO_PPVAP_BIT]) |
			(s_r.dc2_flag & s_r.reg_val[`CPO_PPDC2_BIT]);
		case (s_r.uv_st)
			cpo_pkg::CPO_RUN: begin
				if (uv_now) begin
					if (s_r.reg_val[`CPO_NOHIC_BIT]) begin
						s_nxt.uv_st = cpo_pkg::CPO_LATCH;
					end else begin
						s_nxt.uv_st = cpo_pkg::CPO_HICCUP;
					end
				end else begin
					s_nxt.restarts = 3'h0;
				end
			end
			cpo_pkg::CPO_HICCUP: begin
				if (s_r.restarts == `CPO_MAX_RESTARTS) begin
					s_nxt.uv_st = cpo_pkg::CPO_LATCH;
				end else begin
					s_nxt.restarts = s_r.restarts + 3'h1;
					s_nxt.uv_st    = cpo_pkg::CPO_RUN;
				end
			end
			cpo_pkg::CPO_LATCH: s_nxt.uv_st = cpo_pkg::CPO_LATCH;
			default:            s_nxt.uv_st = cpo_pkg::CPO_RUN;
		endcase
	end

	// =====================================================
	// state register
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_r          <= '0;
			s_r.reg_val  <= `CPO_RESET;
			s_r.rdata    <= `CPO_RESET;
			s_r.uv_st    <= cpo_pkg::CPO_RUN;
		end else begin
			s_r <= s_nxt;
		end
	end

	// =====================================================
	// outputs, all taken from the state flops
	always_comb begin
		reg_rdata_o = s_r.rdata;
		system_undervoltage_threshold_o =
			s_r.reg_val[`CPO_UV_MSB:`CPO_UV_LSB];
		dither_range_o = s_r.reg_val[`CPO_DITH_MSB:`CPO_DITH_LSB];
		discharge_limit2_percent_o =
			s_r.reg_val[`CPO_PCT_MSB:`CPO_PCT_LSB];
		discharge_limit2_trip_o = s_r.dc2_det;
		processor_throttle_o = s_r.throttle;
		// one-hot state bits drive the pins with no decode behind them
		converter_enable_o = s_r.uv_st[0];
		latched_off_o      = s_r.uv_st[2];
	end

	// =====================================================
	// checks
	a_reset_value: assert property (@(posedge mclk_i)
		$fell(sys_rst_i) |-> s_r.reg_val == `CPO_RESET)
		else $error("register not at reset value");
	a_ro_protect: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) (reg_wr_i && hit) |=>
		s_r.reg_val == ($past(reg_wdata_i) & `CPO_RW_MASK))
		else $error("write stored other than writable bits");
	a_flag_sticky: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) (s_r.vap_flag && !(reg_rd_i && hit)) |=>
		s_r.vap_flag)
		else $error("peak flag dropped without read");
	a_flag_set: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) vap_now |=> s_r.vap_flag)
		else $error("peak flag not set");
	a_throttle_gate: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		(!s_r.reg_val[`CPO_PPVAP_BIT] && !s_r.reg_val[`CPO_PPDC2_BIT])
		|=> !processor_throttle_o)
		else $error("throttle without profile enable");
	a_no_hiccup: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) (s_r.uv_st == cpo_pkg::CPO_RUN && uv_now
		&& s_r.reg_val[`CPO_NOHIC_BIT]) |=> latched_off_o)
		else $error("hiccup ran while disabled");
	a_latch_after7: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) (s_r.uv_st == cpo_pkg::CPO_HICCUP
		&& s_r.restarts == 3'h7) |=> latched_off_o)
		else $error("no latch-off after seven restarts");
	a_deg_min: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) $rose(s_r.dc2_det) |->
		$past(s_r.deg_cnt) >= $past(deg_lim) - 18'h00001)
		else $error("limit2 trip before deglitch time");
	a_dither_map: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) (reg_wr_i && hit) |=> dither_range_o ==
		$past(reg_wdata_i[`CPO_DITH_MSB:`CPO_DITH_LSB]))
		else $error("dither field mismatch");
	a_pct_map: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) (reg_wr_i && hit) |=>
		discharge_limit2_percent_o ==
		$past(reg_wdata_i[`CPO_PCT_MSB:`CPO_PCT_LSB]))
		else $error("percent field mismatch");
	a_uv_thresh: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) (reg_wr_i && hit) |=>
		system_undervoltage_threshold_o ==
		$past(reg_wdata_i[`CPO_UV_MSB:`CPO_UV_LSB]))
		else $error("threshold field mismatch");
	a_read_clear: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) (reg_rd_i && hit && !vap_now) |=>
		!s_r.vap_flag)
		else $error("peak flag survived a read");
	a_flag_shown: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) 1'b1 |=>
		reg_rdata_o[`CPO_VAPFLG_BIT] == $past(s_r.vap_flag))
		else $error("peak flag not shown in read data");
	a_throttle_on: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		(s_r.vap_flag && s_r.reg_val[`CPO_PPVAP_BIT])
		|=> processor_throttle_o)
		else $error("enabled peak event did not throttle");
	a_hiccup_run: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) (s_r.uv_st == cpo_pkg::CPO_RUN && uv_now
		&& !s_r.reg_val[`CPO_NOHIC_BIT]) |=>
		s_r.uv_st == cpo_pkg::CPO_HICCUP)
		else $error("hiccup restart skipped while enabled");
	a_latch_hold: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) latched_off_o |=> latched_off_o)
		else $error("latch-off left without reset");
	a_deg_clear: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i) !dc2_now |=> !s_r.dc2_det)
		else $error("limit2 trip held after input dropped");
endmodule // cpo_option_reg

// *** dv/cpo_host_model.sv ***
// host side model issuing register writes and reads
`timescale 1ns/1ns
module cpo_host_model (
	input  wire logic        mclk_i,
	output logic      [7:0]  reg_addr_o,
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	output logic      [15:0] reg_wdata_o,
	input  wire logic [15:0] reg_rdata_i
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 16'h0000;
	end
	// released data shows the inverse so a stale word never matches
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(posedge mclk_i);
		#1;
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask
	// two idle edges let a prior write reach the read data flop
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		repeat (2) @(posedge mclk_i);
		#1;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		// data stands through the strobe cycle; taking it mid-cycle
		// avoids racing the edge that clears the flags
		@(negedge mclk_i);
		d = reg_rdata_i;
		@(posedge mclk_i);
		#1;
		reg_rd_o = 1'b0;
	endtask
endmodule // cpo_host_model

// *** dv/cpo_option_reg_bench.sv ***
// self-checking bench for the protection option register
`timescale 1ns/1ns
module cpo_option_reg_bench;
	logic        mclk_i;
	logic        sys_rst_i;
	logic [7:0]  addr;
	logic        wr;
	logic        rd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] v;
	logic        uv;
	logic        peak;
	logic        dc2;
	logic        ptm;
	logic [2:0]  thr;
	logic [2:0]  pct;
	logic [1:0]  dith;
	logic        trip;
	logic        thr_o;
	logic        en;
	logic        latched;
	int          errors = 0;
	int          checked = 0;
	int          cyc = 0;
	cpo_host_model cpo_host_model_inst (.mclk_i(mclk_i), .reg_addr_o(addr),
		.reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata),
		.reg_rdata_i(rdata));
	cpo_option_reg cpo_option_reg_inst (.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.sys_uv_i(uv), .bus_peak_event_i(peak), .dc2_over_i(dc2),
		.ptm_active_i(ptm), .system_undervoltage_threshold_o(thr),
		.dither_range_o(dith), .discharge_limit2_percent_o(pct),
		.discharge_limit2_trip_o(trip), .processor_throttle_o(thr_o),
		.converter_enable_o(en), .latched_off_o(latched));
	// =========================================================
	// checking and closing
	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			wrap_up;
		end
	end
	// =========================================================
	// scenarios
	initial begin
		sys_rst_i = 1'b1;
		uv = 1'b0;
		peak = 1'b0;
		dc2 = 1'b0;
		ptm = 1'b0;
		repeat (4) @(posedge mclk_i);
		#1;
		sys_rst_i = 1'b0;
		cpo_host_model_inst.rd(8'h36, v);
		chk("reset", v, 16'h0048);
		cpo_host_model_inst.wr(8'h36, 16'hFFFF);
		cpo_host_model_inst.rd(8'h36, v);
		chk("rw", v, 16'hFEFC);
		chk("fields", {8'h00, thr, dith, pct}, 16'h00FF);
		for (int i = 0; i < 4; i++) begin
			cpo_host_model_inst.wr(8'h36, 16'(i) << 11);
			cpo_host_model_inst.rd(8'h36, v);
			chk("dither", {14'h0, dith}, 16'(i));
		end
		cpo_host_model_inst.wr(8'h37, 16'hFFFF);
		cpo_host_model_inst.rd(8'h36, v);
		chk("unmapped", v, 16'h1800);
		cpo_host_model_inst.wr(8'h36, 16'h0200);
		dc2 = 1'b1;
		// three sync edges, then 1000 cycles of deglitch before the trip
		repeat (1002) @(posedge mclk_i);
		#1;
		chk("deg_early", {15'h0, trip}, 16'h0000);
		@(posedge mclk_i);
		#1;
		chk("deg_trip", {15'h0, trip}, 16'h0001);
		dc2 = 1'b0;
		peak = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1;
		peak = 1'b0;
		repeat (6) @(posedge mclk_i);
		chk("throttle", {15'h0, thr_o}, 16'h0001);
		cpo_host_model_inst.rd(8'h36, v);
		chk("flag_set", v, 16'h0302);
		cpo_host_model_inst.rd(8'h36, v);
		chk("flag_clr", v, 16'h0200);
		cpo_host_model_inst.wr(8'h36, 16'h0004);
		ptm = 1'b1;
		peak = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1;
		peak = 1'b0;
		repeat (6) @(posedge mclk_i);
		#1;
		chk("gated", {15'h0, thr_o}, 16'h0000);
		cpo_host_model_inst.rd(8'h36, v);
		chk("flag_ptm", v, 16'h0105);
		cpo_host_model_inst.wr(8'h36, 16'h0400);
		uv = 1'b1;
		repeat (8) @(posedge mclk_i);
		chk("latch", {14'h0, latched, en}, 16'h0002);
		#1;
		sys_rst_i = 1'b1;
		uv = 1'b0;
		ptm = 1'b0;
		repeat (4) @(posedge mclk_i);
		#1;
		sys_rst_i = 1'b0;
		cpo_host_model_inst.rd(8'h36, v);
		chk("reset2", v, 16'h0048);
		chk("run2", {14'h0, latched, en}, 16'h0001);
		uv = 1'b1;
		// seven one-cycle restarts fail, then the eighth hiccup latches
		repeat (17) @(posedge mclk_i);
		#1;
		chk("retry7_run", {14'h0, latched, en}, 16'h0001);
		@(posedge mclk_i);
		#1;
		chk("retry7_hic", {14'h0, latched, en}, 16'h0000);
		@(posedge mclk_i);
		#1;
		chk("latch7", {14'h0, latched, en}, 16'h0002);
		wrap_up;
	end
endmodule // cpo_option_reg_bench
